// *** ecsd_debug_top.sv ***
// Standalone debug path into the error calculator, APB slave
// What this block does
// - Each shift toggle moves the 9-bit symbol field into the syndrome array.
// - A toggle of the shift bit, not its level, is the shift command.
// - In standalone mode a kick toggle starts the solver exactly as a bus master start would.
// - In standalone mode the payload kind bit drives the solver payload flag.
// - In standalone mode the large page bit drives the solver 4K mode input.
// - A read-only version register holds fixed major, minor and stepping fields.
module ecsd_debug_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Normal start and mode inputs from the bus master path
  input wire logic master_start,
  input wire logic master_payload_flag,
  input wire logic master_large_page,
  // Solver interface
  output logic solver_start,
  output logic solver_payload_flag,
  output logic solver_large_page,
  output logic [ecsd_pkg::ECSD_SYNDROME_DEPTH*ecsd_pkg::ECSD_SYMBOL_WIDTH-1:0] solver_syndromes
);
  import ecsd_pkg::*;

  // Decode a word address to its register
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] offs);
    is_reg = (addr[11:2] == offs[11:2]);
  endfunction

  logic [31:0] debug_reg, debug_next;
  logic shift_prev_reg, shift_prev_next;
  logic kick_prev_reg, kick_prev_next;
  logic [4:0] count_reg, count_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic start_reg, start_next;
  logic payload_reg, payload_next;
  logic page_reg, page_next;
  logic shift_pulse, kick_pulse, standalone;
  logic apb_setup, apb_access, known;

  // Zero-wait-state access: answer in the cycle after setup
  assign apb_setup = psel && !penable && !pready_reg;
  // Access phase that completes at this edge
  assign apb_access = psel && penable && pready_reg;
  assign known = is_reg(paddr, ECSD_DEBUG_OFFSET) || is_reg(paddr, ECSD_VERSION_OFFSET)
    || is_reg(paddr, ECSD_STATUS_OFFSET);

  // Toggle detection against registered copies
  assign shift_pulse = debug_reg[ECSD_SHIFT_BIT] ^ shift_prev_reg;
  assign kick_pulse = debug_reg[ECSD_KICK_BIT] ^ kick_prev_reg;
  assign standalone = debug_reg[ECSD_STANDALONE_BIT];

  // Register writes, reads and answer
  always_comb begin
    debug_next = debug_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (apb_setup) begin
      pready_next = 1'b1;
      pslverr_next = !known;
      prdata_next = 32'h0000_0000;
      if (!pwrite) begin
        if (is_reg(paddr, ECSD_DEBUG_OFFSET)) begin
          prdata_next = debug_reg;
        end else if (is_reg(paddr, ECSD_VERSION_OFFSET)) begin
          prdata_next = {ECSD_VERSION_MAJOR, ECSD_VERSION_MINOR, ECSD_VERSION_STEP};
        end else if (is_reg(paddr, ECSD_STATUS_OFFSET)) begin
          prdata_next = {27'h0000000, count_reg};
        end
      end
    end
    // Writes land only at the edge that completes the access phase
    if (apb_access && pwrite && is_reg(paddr, ECSD_DEBUG_OFFSET)) begin
      debug_next = pwdata & ECSD_DEBUG_WMASK;
    end
  end

  // Toggle history, symbol count and solver drive
  always_comb begin
    shift_prev_next = debug_reg[ECSD_SHIFT_BIT];
    kick_prev_next = debug_reg[ECSD_KICK_BIT];
    count_next = count_reg;
    if (shift_pulse && count_reg != 5'(ECSD_SYNDROME_DEPTH)) begin
      count_next = count_reg + 5'h01;
    end
    if (kick_pulse) begin
      count_next = 5'h00;
    end
    start_next = standalone ? kick_pulse : master_start;
    payload_next = standalone ? debug_reg[ECSD_PAYLOAD_BIT] : master_payload_flag;
    page_next = standalone ? debug_reg[ECSD_LARGE_PAGE_BIT] : master_large_page;
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      debug_reg <= ECSD_DEBUG_RESET;
      shift_prev_reg <= 1'b0;
      kick_prev_reg <= 1'b0;
      count_reg <= 5'h00;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      start_reg <= 1'b0;
      payload_reg <= 1'b0;
      page_reg <= 1'b0;
    end else begin
      debug_reg <= debug_next;
      shift_prev_reg <= shift_prev_next;
      kick_prev_reg <= kick_prev_next;
      count_reg <= count_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      start_reg <= start_next;
      payload_reg <= payload_next;
      page_reg <= page_next;
    end
  end

  // Syndrome array, shifted once per toggle
  ecsd_syndrome_array u_array (
    .clk(clk),
    .rst_n(rst_n),
    .shift_en(shift_pulse),
    .symbol_in(debug_reg[ECSD_SYMBOL_MSB:ECSD_SYMBOL_LSB]),
    .syndromes(solver_syndromes)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign solver_start = start_reg;
  assign solver_payload_flag = payload_reg;
  assign solver_large_page = page_reg;

  // Assertions

  // A shift toggle loads the symbol field into the newest entry
  shift_moves_symbol_a: assert property (@(posedge clk) disable iff (!rst_n)
    shift_pulse |=> solver_syndromes[ECSD_SYMBOL_WIDTH-1:0]
      == $past(debug_reg[ECSD_SYMBOL_MSB:ECSD_SYMBOL_LSB]))
    else $error("shift did not load symbol");

  // A held shift level never moves the array
  level_no_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!shift_pulse && $stable(debug_reg)) |=> $stable(solver_syndromes))
    else $error("array moved without toggle");

  // A kick toggle in standalone mode starts the solver
  kick_starts_a: assert property (@(posedge clk) disable iff (!rst_n)
    (kick_pulse && standalone) |=> solver_start)
    else $error("kick did not start solver");

  // Outside standalone mode a kick toggle does not start the solver
  kick_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
    (kick_pulse && !standalone && !master_start) |=> !solver_start)
    else $error("kick started solver outside standalone");

  // Outside standalone mode the master start passes through
  master_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!standalone) |=> solver_start == $past(master_start))
    else $error("master start not passed");

  // Payload kind bit reaches the solver in standalone mode
  payload_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    standalone |=> solver_payload_flag == $past(debug_reg[ECSD_PAYLOAD_BIT]))
    else $error("payload flag wrong");

  // Large page bit reaches the solver in standalone mode
  page_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    standalone |=> solver_large_page == $past(debug_reg[ECSD_LARGE_PAGE_BIT]))
    else $error("page mode wrong");

  // Version reads return the fixed word
  version_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (apb_setup && !pwrite && is_reg(paddr, ECSD_VERSION_OFFSET))
    |=> prdata == {ECSD_VERSION_MAJOR, ECSD_VERSION_MINOR, ECSD_VERSION_STEP})
    else $error("version value wrong");

  // In standalone mode every kick change, rising or falling, gives exactly one start pulse
  toggle_each_way_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(debug_reg[ECSD_KICK_BIT]) && standalone) |=> solver_start ##1 !solver_start)
    else $error("toggle not seen once");

  // One answer cycle per taken setup
  apb_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_setup |=> pready ##1 !pready)
    else $error("apb answer timing");

  // Writes reach the debug register at the end of the access phase
  write_on_access_a: assert property (@(posedge clk) disable iff (!rst_n)
    (apb_access && pwrite && is_reg(paddr, ECSD_DEBUG_OFFSET))
    |=> debug_reg == ($past(pwdata) & ECSD_DEBUG_WMASK))
    else $error("debug write not applied");

  // Unmapped addresses answer with an error and zero data
  unmapped_error_a: assert property (@(posedge clk) disable iff (!rst_n)
    (apb_setup && !known) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  // Bits outside the writable field always stay zero
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (debug_reg & ~ECSD_DEBUG_WMASK) == 32'h0000_0000)
    else $error("reserved debug bits set");

  // The symbol count never passes the array depth
  count_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_reg <= 5'(ECSD_SYNDROME_DEPTH))
    else $error("symbol count overflow");

  // Main scenarios
  shift_cov: cover property (@(posedge clk) disable iff (!rst_n) shift_pulse);
  kick_cov: cover property (@(posedge clk) disable iff (!rst_n) kick_pulse && standalone);
  full_cov: cover property (@(posedge clk) disable iff (!rst_n)
    count_reg == 5'(ECSD_SYNDROME_DEPTH));
  kick_fall_cov: cover property (@(posedge clk) disable iff (!rst_n)
    kick_pulse && standalone && !debug_reg[ECSD_KICK_BIT]);
  unmapped_cov: cover property (@(posedge clk) disable iff (!rst_n) apb_setup && !known);
endmodule

// *** ecsd_debug_top_tb.sv ***
// Self-checking bench for the solver standalone debug block
module ecsd_debug_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ecsd_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic master_start, master_payload_flag, master_large_page;
  logic solver_start, solver_payload_flag, solver_large_page;
  logic [ECSD_SYNDROME_DEPTH*ECSD_SYMBOL_WIDTH-1:0] solver_syndromes;
  logic [8:0] sym;
  logic [8:0] exp_q [16];
  logic sh, pay, lp, kk, sa;
  int n_fail, check_count, n;
  ecsd_debug_top i_ecsd_debug_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .master_start, .master_payload_flag, .master_large_page,
    .solver_start, .solver_payload_flag, .solver_large_page, .solver_syndromes);
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1);
    chk(k, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Debug word from the bench's own field copies
  function automatic logic [31:0] dbg_word();
    return {7'h00, sym, sh, pay, lp, kk, sa, 11'h000};
  endfunction
  // Count start pulses over a short window
  task automatic count_starts();
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (solver_start === 1'h1) n++;
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Clock at 100 ns
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, sym, sh, pay, lp, kk, sa} = '0;
    {master_start, master_payload_flag, master_large_page} = '0;
    foreach (exp_q[i]) exp_q[i] = '0;
    void'($urandom(32'hC25BA5E3));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h1, ECSD_VERSION_OFFSET, 32'hFFFFFFFF);
    apb(1'h0, ECSD_VERSION_OFFSET, 32'h0);
    chk(rd, {ECSD_VERSION_MAJOR, ECSD_VERSION_MINOR, ECSD_VERSION_STEP});
    chk(32'(err), 32'h0);
    apb(1'h0, 12'h0FC, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    // Sixteen symbols and two more, each by a toggle in either direction
    for (int i = 0; i < 18; i++) begin
      sym = 9'($urandom);
      sh = ~sh;
      apb(1'h1, ECSD_DEBUG_OFFSET, dbg_word());
      for (int j = 15; j > 0; j--) exp_q[j] = exp_q[j-1];
      exp_q[0] = sym;
      repeat (2) @(posedge clk);
      #1;
      foreach (exp_q[j]) chk(solver_syndromes[j*9 +: 9], exp_q[j]);
    end
    // New symbol but the shift bit left as is: no shift
    sym = ~sym;
    apb(1'h1, ECSD_DEBUG_OFFSET, dbg_word());
    repeat (3) @(posedge clk);
    #1;
    foreach (exp_q[j]) chk(solver_syndromes[j*9 +: 9], exp_q[j]);
    apb(1'h0, ECSD_DEBUG_OFFSET, 32'h0);
    chk(rd, dbg_word() & ECSD_DEBUG_WMASK);
    // Symbol count saturates at the array depth
    apb(1'h0, ECSD_STATUS_OFFSET, 32'h0);
    chk(rd, 32'(ECSD_SYNDROME_DEPTH));
    // Standalone mode set before kicking, after the eighteen shifts
    sa = 1'h1;
    for (int i = 0; i < 4; i++) begin
      {pay, lp} = 2'($urandom);
      apb(1'h1, ECSD_DEBUG_OFFSET, dbg_word());
      @(posedge clk);
      #1;
      chk({solver_payload_flag, solver_large_page}, {pay, lp});
    end
    for (int i = 0; i < 2; i++) begin
      kk = ~kk;
      apb(1'h1, ECSD_DEBUG_OFFSET, dbg_word());
      count_starts();
      chk(n, 1);
    end
    // A kick clears the symbol count
    apb(1'h0, ECSD_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    // Outside standalone mode the master path drives the solver
    sa = 1'h0;
    kk = ~kk;
    apb(1'h1, ECSD_DEBUG_OFFSET, dbg_word());
    count_starts();
    chk(n, 0);
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      master_payload_flag <= 1'($urandom);
      master_large_page <= 1'($urandom);
      master_start <= 1'h1;
      @(posedge clk);
      master_start <= 1'h0;
      #1;
      chk({solver_start, solver_payload_flag, solver_large_page},
        {1'h1, master_payload_flag, master_large_page});
      @(posedge clk);
    end
    wrap_up();
  end
endmodule

// *** ecsd_pkg.sv ***
// Package for the solver standalone debug block: offsets, fields, reset values
package ecsd_pkg;
  // Register byte addresses
  localparam logic [11:0] ECSD_DEBUG_OFFSET = 12'h000;
  localparam logic [11:0] ECSD_VERSION_OFFSET = 12'h004;
  localparam logic [11:0] ECSD_STATUS_OFFSET = 12'h008;
  // Debug control field positions
  localparam int ECSD_SYMBOL_MSB = 24;
  localparam int ECSD_SYMBOL_LSB = 16;
  localparam int ECSD_SHIFT_BIT = 15;
  localparam int ECSD_PAYLOAD_BIT = 14;
  localparam int ECSD_LARGE_PAGE_BIT = 13;
  localparam int ECSD_KICK_BIT = 12;
  localparam int ECSD_STANDALONE_BIT = 11;
  // Writable mask of the debug control register
  localparam logic [31:0] ECSD_DEBUG_WMASK = 32'h01FF_F800;
  localparam logic [31:0] ECSD_DEBUG_RESET = 32'h0000_0000;
  // Syndrome array geometry
  localparam int ECSD_SYMBOL_WIDTH = 9;
  localparam int ECSD_SYNDROME_DEPTH = 16;
  // Version fields (values arbitrary)
  localparam logic [7:0] ECSD_VERSION_MAJOR = 8'h02;
  localparam logic [7:0] ECSD_VERSION_MINOR = 8'h00;
  localparam logic [15:0] ECSD_VERSION_STEP = 16'h0000;
endpackage

// *** ecsd_syndrome_array.sv ***
// Syndrome shift register array feeding the solver input
module ecsd_syndrome_array (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Shift request
  input wire logic shift_en,
  input wire logic [ecsd_pkg::ECSD_SYMBOL_WIDTH-1:0] symbol_in,
  // Flattened array, entry 0 is the newest symbol
  output logic [ecsd_pkg::ECSD_SYNDROME_DEPTH*ecsd_pkg::ECSD_SYMBOL_WIDTH-1:0] syndromes
);
  import ecsd_pkg::*;
  localparam int W = ECSD_SYMBOL_WIDTH;
  localparam int D = ECSD_SYNDROME_DEPTH;
  logic [D*W-1:0] array_reg;
  logic [D*W-1:0] array_next;

  // Shift by one symbol on each request
  always_comb begin
    array_next = array_reg;
    if (shift_en) begin
      array_next = {array_reg[(D-1)*W-1:0], symbol_in};
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      array_reg <= '0;
    end else begin
      array_reg <= array_next;
    end
  end

  assign syndromes = array_reg;
endmodule
